// [rtl/boot_seq_pkg.sv]
package boot_seq_pkg;

   localparam int CLK_HZ = 20_000_000;

   // header flag values that mark a programmed application
   localparam logic [63:0] APP_FLAG1 = 64'h1234A5A51234A5A5;
   localparam logic [63:0] APP_FLAG2 = 64'hA5A51234A5A51234;
   localparam int CALIB_HI = 31;
   localparam int CALIB_LO = 16;
   localparam logic [15:0] CALIB_PATTERN = 16'hA5A5;

   // probe rates
   localparam int BAUD_A = 57600;
   localparam int BAUD_B = 115200;
   localparam int BAUD_C = 57600;
   localparam int BAUD_D = 9600;
   localparam int SPI_HZ_0 = 8_000_000;
   localparam int SPI_HZ_1 = 4_000_000;
   localparam int SPI_HZ_2 = 2_000_000;
   localparam int SPI_HZ_3 = 1_000_000;
   localparam int I2C_HZ = 100_000;
   localparam logic [15:0] DIV_UART_A = 16'(CLK_HZ / BAUD_A);
   localparam logic [15:0] DIV_UART_B = 16'(CLK_HZ / BAUD_B);
   localparam logic [15:0] DIV_UART_C = 16'(CLK_HZ / BAUD_C);
   localparam logic [15:0] DIV_UART_D = 16'(CLK_HZ / BAUD_D);
   localparam logic [15:0] DIV_SPI_0 = 16'(CLK_HZ / SPI_HZ_0);
   localparam logic [15:0] DIV_SPI_1 = 16'(CLK_HZ / SPI_HZ_1);
   localparam logic [15:0] DIV_SPI_2 = 16'(CLK_HZ / SPI_HZ_2);
   localparam logic [15:0] DIV_SPI_3 = 16'(CLK_HZ / SPI_HZ_3);
   localparam logic [15:0] DIV_I2C = 16'(CLK_HZ / I2C_HZ);

   // answer timeout: header value counts units of this many microseconds
   localparam int TIMEOUT_UNIT_US = 100;
   localparam int TIMEOUT_UNIT_CYC = TIMEOUT_UNIT_US * (CLK_HZ / 1_000_000);
   localparam logic [15:0] TIMEOUT_DEFAULT_UNITS = 16'h0032;

   // probe step numbers
   localparam logic [3:0] STEP_FIRST = 4'h0;
   localparam logic [3:0] STEP_SPI_SLAVE_B = 4'h1;
   localparam logic [3:0] STEP_UART_A = 4'h2;
   localparam logic [3:0] STEP_UART_D = 4'h5;
   localparam logic [3:0] STEP_SPI_MASTER = 4'h6;
   localparam logic [3:0] STEP_I2C_A = 4'h7;
   localparam logic [3:0] STEP_LAST = 4'hA;
   localparam logic [3:0] STEP_USER_SPI = 4'hB;
   localparam logic [1:0] SPI_MASTER_ITER_LAST = 2'h3;

   typedef enum logic [1:0] {
      if_spi_slave,
      if_uart,
      if_spi_master,
      if_i2c
   } iface_e;

   typedef struct packed {
      logic [63:0] app_flag1;
      logic [63:0] app_flag2;
      logic [31:0] calib_flags;
      logic user_spi_en;
      logic [11:0] user_spi_pins;
      logic [15:0] uart_timeout;
   } header_s;

   typedef struct packed {
      iface_e iface;
      logic [3:0] step;
      logic [1:0] iter;
      logic [15:0] rate_div;
      logic send;
   } probe_s;

endpackage : boot_seq_pkg

// [rtl/probe_timer.sv]
`timescale 1ns/1ns
module probe_timer
   import boot_seq_pkg::*;
#(
   parameter int UNIT_CYC = TIMEOUT_UNIT_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [15:0] units,
   output logic expired
);
   initial begin
      if (UNIT_CYC < 1 || UNIT_CYC > 65535) $error("probe_timer: bad UNIT_CYC");
   end

   logic [15:0] pre;
   logic [15:0] left;
   logic running;
   wire unit_tick = running && (pre == 16'h0000);
   wire last_unit = unit_tick && (left == 16'h0001);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pre <= 16'h0000;
         left <= 16'h0000;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= last_unit;
         if (load) begin
            pre <= 16'(UNIT_CYC - 1);
            left <= (units == 16'h0000) ? 16'h0001 : units;
            running <= 1'b1;
         end else if (unit_tick) begin
            pre <= 16'(UNIT_CYC - 1);
            left <= left - 16'h0001;
            running <= !last_unit;
         end else if (running) begin
            pre <= pre - 16'h0001;
         end
      end
   end
endmodule : probe_timer

// [rtl/probe_pin_router.sv]
`timescale 1ns/1ns
module probe_pin_router
   import boot_seq_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic active,
   input wire logic [3:0] step,
   input wire logic [11:0] user_pins,
   input wire logic [3:0] role_out,
   input wire logic [3:0] role_oe,
   output logic [3:0] role_in,
   input wire logic [7:0] port0_pin_in,
   output logic [7:0] port0_pin_out,
   output logic [7:0] port0_pin_oe
);
   // pin number used by a line role in a step
   function automatic logic [2:0] pin_of(input logic [3:0] s, input int r,
                                         input logic [11:0] up);
      logic [2:0] spi_a [4];
      logic [3:0] k;
      spi_a = '{3'h0, 3'h3, 3'h6, 3'h5};
      k = 4'h0;
      if (s == STEP_FIRST || s == STEP_SPI_MASTER) pin_of = spi_a[r];
      else if (s == STEP_SPI_SLAVE_B) pin_of = 3'(r);
      else if (s == STEP_USER_SPI) pin_of = up[r*3 +: 3];
      else begin
         k = (s >= STEP_I2C_A) ? s - STEP_I2C_A : s - STEP_UART_A;
         pin_of = 3'({k[1:0], 1'b0} + r[0]);
      end
   endfunction : pin_of

   wire four_lines = (step <= STEP_SPI_SLAVE_B) || (step == STEP_SPI_MASTER)
                     || (step == STEP_USER_SPI);
   logic [2:0] sel [4];
   logic [3:0] used;

   genvar r, p;
   generate
      for (r = 0; r < 4; r++) begin : g_role
         assign sel[r] = pin_of(step, r, user_pins);
         assign used[r] = active && (r < 2 || four_lines);
         assign role_in[r] = used[r] ? port0_pin_in[sel[r]] : 1'b1;
      end
      for (p = 0; p < 8; p++) begin : g_pin
         wire [3:0] hit;
         for (r = 0; r < 4; r++) begin : g_hit
            assign hit[r] = used[r] && (sel[r] == 3'(p));
         end
         wire drv = |(hit & role_oe);
         wire val = |(hit & role_out);
         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               port0_pin_out[p] <= 1'b0;
               port0_pin_oe[p] <= 1'b0;
            end else begin
               port0_pin_out[p] <= val;
               port0_pin_oe[p] <= drv;
            end
         end
      end
   endgenerate
endmodule : probe_pin_router

// [rtl/boot_probe_sequencer.sv]
`timescale 1ns/1ns
// Function
// - read both header flag words; normal mode only on predefined value
// - all-zero flags select development mode
// - other flag values: report faulty memory, still enable peripherals
// - development mode first initialises UART, SPI both roles and I2C
// - probe steps 0..10: SPI slave A,B, UART A-D, SPI master, I2C A-D
// - SPI slave step A on pins 0,3,6,5; step B on pins 0,1,2,3
// - UART and I2C steps A-D use pin pairs 0/1, 2/3, 4/5, 6/7
// - UART step A 57600, step B 115200, both 8-N-1
// - UART step C 57600, step D 9600, both 8-N-1
// - SPI master step uses pins 0,3,6,5 for clock, select, out, in
// - SPI master step runs four times at 8, 4, 2, 1 MHz
// - every I2C step clocks at 100 kbit/s
// - each step sends a defined character then waits for an answer
// - no answer before timeout: move on to the next step
// - on an answer both sides run the download protocol
// - user SPI configuration in header: try only that SPI path first
// - failed user SPI attempt falls back to the standard probe sequence
// - normal mode loads header configuration, checks calibration bits 31:16
// - then copy application into system RAM and run the patch routine
// - then set the remap field so address zero maps to system RAM
// - finally issue a software reset
// - boot runs only after power-up or hardware reset, not after wake-up
// - header timeout value sets the wait for an answer
module boot_probe_sequencer
   import boot_seq_pkg::*;
#(
   parameter int UNIT_CYC = TIMEOUT_UNIT_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cold_start,
   output logic hdr_req,
   input wire logic hdr_valid,
   input wire header_s header,
   output logic dev_mode,
   output logic normal_mode,
   output logic otp_fault,
   output logic periph_init,
   output logic periph_enable,
   output probe_s probe,
   input wire logic answer,
   input wire logic [3:0] role_out,
   input wire logic [3:0] role_oe,
   output logic [3:0] role_in,
   input wire logic [7:0] port0_pin_in,
   output logic [7:0] port0_pin_out,
   output logic [7:0] port0_pin_oe,
   output logic dl_start,
   input wire logic dl_done,
   input wire logic dl_fail,
   output logic cfg_load,
   output logic calib_ok,
   output logic copy_req,
   input wire logic copy_done,
   output logic patch_req,
   input wire logic patch_done,
   output logic address_zero_remap_field,
   output logic sw_reset,
   output logic boot_done
);
   initial begin
      if (UNIT_CYC < 1 || UNIT_CYC > 65535) $error("boot_probe_sequencer: bad UNIT_CYC");
   end

   typedef enum logic [3:0] {
      st_idle,
      st_read,
      st_decide,
      st_init,
      st_send,
      st_wait,
      st_download,
      st_cfg,
      st_copy,
      st_patch,
      st_remap,
      st_reset,
      st_fault,
      st_done
   } state_e;

   // rate divider for a step and SPI master iteration
   function automatic logic [15:0] rate_of(input logic [3:0] s, input logic [1:0] it);
      case (s)
         4'h2: rate_of = DIV_UART_A;
         4'h3: rate_of = DIV_UART_B;
         4'h4: rate_of = DIV_UART_C;
         4'h5: rate_of = DIV_UART_D;
         STEP_SPI_MASTER: begin
            case (it)
               2'h0: rate_of = DIV_SPI_0;
               2'h1: rate_of = DIV_SPI_1;
               2'h2: rate_of = DIV_SPI_2;
               default: rate_of = DIV_SPI_3;
            endcase
         end
         4'h7, 4'h8, 4'h9, STEP_LAST: rate_of = DIV_I2C;
         default: rate_of = 16'h0000;
      endcase
   endfunction : rate_of

   function automatic iface_e iface_of(input logic [3:0] s);
      if (s <= STEP_SPI_SLAVE_B || s == STEP_USER_SPI) iface_of = if_spi_slave;
      else if (s <= STEP_UART_D) iface_of = if_uart;
      else if (s == STEP_SPI_MASTER) iface_of = if_spi_master;
      else iface_of = if_i2c;
   endfunction : iface_of

   state_e state;
   state_e next_state;
   header_s hdr;
   logic armed;
   logic seen;
   logic [3:0] step;
   logic [1:0] iter;
   logic expired;

   // header decode
   wire flags_app = (hdr.app_flag1 == APP_FLAG1) && (hdr.app_flag2 == APP_FLAG2);
   wire flags_blank = (hdr.app_flag1 == 64'h0) && (hdr.app_flag2 == 64'h0);
   wire calib_match = hdr.calib_flags[CALIB_HI:CALIB_LO] == CALIB_PATTERN;
   wire [15:0] wait_units = (hdr.uart_timeout == 16'h0000) ? TIMEOUT_DEFAULT_UNITS
                            : hdr.uart_timeout;

   // step advance after a timeout or failed download
   wire from_user = step == STEP_USER_SPI;
   wire master_again = (step == STEP_SPI_MASTER) && (iter != SPI_MASTER_ITER_LAST);
   wire [3:0] next_step = from_user ? STEP_FIRST
                          : master_again ? step
                          : (step == STEP_LAST) ? STEP_FIRST
                          : step + 4'h1;
   wire [1:0] next_iter = master_again ? iter + 2'h1 : 2'h0;
   wire probing = (state == st_send) || (state == st_wait) || (state == st_download);

   always_comb begin
      next_state = state;
      case (state)
         st_idle: if (armed) next_state = st_read;
         st_read: if (hdr_valid) next_state = st_decide;
         st_decide: begin
            if (flags_app) next_state = st_cfg;
            else if (flags_blank) next_state = st_init;
            else next_state = st_fault;
         end
         st_init: next_state = st_send;
         st_send: next_state = st_wait;
         st_wait: begin
            if (answer) next_state = st_download;
            else if (expired) next_state = st_send;
         end
         st_download: begin
            if (dl_done) next_state = st_done;
            else if (dl_fail) next_state = st_send;
         end
         st_cfg: next_state = st_copy;
         st_copy: if (copy_done) next_state = st_patch;
         st_patch: if (patch_done) next_state = st_remap;
         st_remap: next_state = st_reset;
         st_reset: next_state = st_done;
         st_fault: next_state = st_fault;
         st_done: next_state = st_done;
         default: next_state = st_idle;
      endcase
   end

   wire leave_step = ((state == st_wait) && !answer && expired)
                     || ((state == st_download) && !dl_done && dl_fail);

   // power-up capture: a wake-up leaves the sequencer idle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         seen <= 1'b0;
         armed <= 1'b0;
      end else begin
         seen <= 1'b1;
         if (!seen) armed <= cold_start;
         else if (state == st_idle && armed) armed <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= st_idle;
         hdr <= '0;
      end else begin
         state <= next_state;
         if (state == st_read && hdr_valid) hdr <= header;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         step <= STEP_FIRST;
         iter <= 2'h0;
      end else if (state == st_init) begin
         step <= hdr.user_spi_en ? STEP_USER_SPI : STEP_FIRST;
         iter <= 2'h0;
      end else if (leave_step) begin
         step <= next_step;
         iter <= next_iter;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dev_mode <= 1'b0;
         normal_mode <= 1'b0;
         otp_fault <= 1'b0;
         periph_init <= 1'b0;
         periph_enable <= 1'b0;
         dl_start <= 1'b0;
         cfg_load <= 1'b0;
         calib_ok <= 1'b0;
         address_zero_remap_field <= 1'b0;
         sw_reset <= 1'b0;
         boot_done <= 1'b0;
      end else begin
         periph_init <= state == st_init;
         dl_start <= (state == st_wait) && answer;
         cfg_load <= state == st_cfg;
         sw_reset <= state == st_reset;
         if (state == st_decide) begin
            normal_mode <= flags_app;
            dev_mode <= flags_blank;
            otp_fault <= !flags_app && !flags_blank;
            periph_enable <= !flags_app;
         end
         if (state == st_cfg) calib_ok <= calib_match;
         if (state == st_remap) address_zero_remap_field <= 1'b1;
         if (next_state == st_done && state != st_done) boot_done <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         probe <= '0;
      end else begin
         probe.iface <= iface_of(step);
         probe.step <= step;
         probe.iter <= iter;
         probe.rate_div <= rate_of(step, iter);
         probe.send <= state == st_send;
      end
   end

   assign hdr_req = state == st_read;
   assign copy_req = state == st_copy;
   assign patch_req = state == st_patch;

   probe_timer #(
      .UNIT_CYC(UNIT_CYC)
   ) u_timer (
      .mclk(mclk),
      .nrst(nrst),
      .load(state == st_send),
      .units(wait_units),
      .expired(expired)
   );

   // step pin maps: slave A/B, UART and I2C pairs, master
   probe_pin_router u_router (
      .mclk(mclk),
      .nrst(nrst),
      .active(probing),
      .step(step),
      .user_pins(hdr.user_spi_pins),
      .role_out(role_out),
      .role_oe(role_oe),
      .role_in(role_in),
      .port0_pin_in(port0_pin_in),
      .port0_pin_out(port0_pin_out),
      .port0_pin_oe(port0_pin_oe)
   );
endmodule : boot_probe_sequencer

// [tb/boot_probe_sequencer_chk.sv]
`timescale 1ns/1ns
module boot_probe_sequencer_chk
   import boot_seq_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire header_s header,
   input wire probe_s probe,
   input wire logic answer,
   input wire logic dl_start,
   input wire logic dev_mode,
   input wire logic normal_mode,
   input wire logic otp_fault,
   input wire logic periph_enable,
   input wire logic cfg_load,
   input wire logic calib_ok,
   input wire logic copy_req,
   input wire logic copy_done,
   input wire logic patch_req,
   input wire logic address_zero_remap_field,
   input wire logic sw_reset
);
   logic [15:0] spi_div;
   assign spi_div = probe.iter == 2'h0 ? DIV_SPI_0 : probe.iter == 2'h1 ? DIV_SPI_1 :
      probe.iter == 2'h2 ? DIV_SPI_2 : DIV_SPI_3;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   sequence s_copy_handoff;
      copy_req && copy_done;
   endsequence
   sequence s_remap_set;
      $rose(address_zero_remap_field);
   endsequence
   property p_one_mode;
      !(dev_mode && normal_mode) && !(otp_fault && (dev_mode || normal_mode));
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("two modes");
   property p_periph_on;
      $rose(dev_mode || otp_fault) |-> ##[0:2] periph_enable;
   endproperty
   a_periph_on: assert property (p_periph_on) else $error("no periph");
   property p_send_pulse;
      probe.send |=> !probe.send;
   endproperty
   a_send_pulse: assert property (p_send_pulse) else $error("long send");
   property p_i2c_rate;
      probe.send && probe.iface == if_i2c |-> probe.rate_div == DIV_I2C;
   endproperty
   a_i2c_rate: assert property (p_i2c_rate) else $error("i2c rate");
   property p_spi_rate;
      probe.send && probe.step == STEP_SPI_MASTER |-> probe.rate_div == spi_div;
   endproperty
   a_spi_rate: assert property (p_spi_rate) else $error("spi rate");
   property p_dl_answer;
      dl_start |-> $past(answer);
   endproperty
   a_dl_answer: assert property (p_dl_answer) else $error("dl no answer");
   property p_patch_after_copy;
      s_copy_handoff |-> ##[1:2] patch_req;
   endproperty
   a_patch_after_copy: assert property (p_patch_after_copy) else $error("no patch");
   property p_calib;
      cfg_load |=> calib_ok == (header.calib_flags[CALIB_HI:CALIB_LO] == CALIB_PATTERN);
   endproperty
   a_calib: assert property (p_calib) else $error("calib flag");
   property p_reset_after_remap;
      s_remap_set |-> ##[1:3] sw_reset;
   endproperty
   a_reset_after_remap: assert property (p_reset_after_remap) else $error("no reset");
   property p_remap_sticks;
      address_zero_remap_field |=> address_zero_remap_field;
   endproperty
   a_remap_sticks: assert property (p_remap_sticks) else $error("remap lost");
endmodule : boot_probe_sequencer_chk

// [tb/boot_host_model.sv]
`timescale 1ns/1ns
module boot_host_model
   import boot_seq_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire probe_s probe,
   input wire logic dl_start,
   input wire logic [3:0] ans_step,
   input wire logic fail_dl,
   output logic answer,
   output logic dl_done,
   output logic dl_fail
);
   logic [2:0] busy;
   logic fail_now;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         answer <= 1'b0;
         dl_done <= 1'b0;
         dl_fail <= 1'b0;
         busy <= 3'h0;
         fail_now <= 1'b0;
      end else begin
         dl_fail <= 1'b0;
         if (probe.send && probe.step == ans_step) begin
            answer <= 1'b1;
         end
         if (dl_start) begin
            answer <= 1'b0;
            busy <= 3'h5;
            fail_now <= fail_dl;
         end else if (busy != 3'h0) begin
            busy <= busy - 3'h1;
            dl_done <= busy == 3'h1 && !fail_now;
            dl_fail <= busy == 3'h1 && fail_now;
         end
      end
   end
endmodule : boot_host_model

// [tb/boot_probe_sequencer_tb.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("wrong value at %0t: %0h vs %0h", $time, a, b); end end
module boot_probe_sequencer_tb;
   import boot_seq_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic cold_start = 1'b1;
   logic hdr_valid = 1'b1;
   header_s header = '0;
   logic [3:0] role_out = 4'h1;
   logic [3:0] role_oe = 4'h1;
   logic [7:0] port0_pin_in = 8'hFF;
   logic copy_done = 1'b0;
   logic patch_done = 1'b0;
   logic [3:0] ans_step = 4'hF;
   logic fail_dl = 1'b0;
   logic hdr_req, dev_mode, normal_mode, otp_fault, periph_init, periph_enable, answer;
   logic dl_start, dl_done, dl_fail, cfg_load, calib_ok, copy_req, patch_req;
   logic address_zero_remap_field, sw_reset, boot_done;
   logic [3:0] role_in;
   logic [7:0] port0_pin_out, port0_pin_oe;
   probe_s probe;
   int fails = 0;
   int checked = 0;
   int n;
   boot_probe_sequencer #(.UNIT_CYC(4)) i_boot_probe_sequencer (.*);
   boot_host_model i_boot_host_model (.*);
   always #25 mclk = ~mclk;
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #5;
   endtask : tick
   task automatic restart(input logic cold, input logic [15:0] tmo);
      nrst = 1'b0;
      cold_start = cold;
      header = '0;
      header.uart_timeout = tmo;
      tick(3);
   endtask : restart
   task automatic wait_send(output int g);
      g = 0;
      do begin
         tick(1);
         g++;
      end while (probe.send !== 1'b1 && g < 400);
      `CHK(probe.send, 1'b1)
   endtask : wait_send
   task automatic run_probes(input int first, input int cnt, input bit gaps);
      int g;
      int idx;
      logic [3:0] s;
      logic [2:0] p;
      logic [15:0] d;
      iface_e e;
      for (int i = first; i < first + cnt; i++) begin
         wait_send(g);
         idx = i % 14;
         s = 4'(idx < 6 ? idx : idx < 10 ? 6 : idx - 3);
         p = 3'(s < 2 || s == 6 ? 0 : s < 6 ? 2 * (s - 2) : 2 * (s - 7));
         e = s < 2 ? if_spi_slave : s < 6 ? if_uart : s == 6 ? if_spi_master : if_i2c;
         d = s == 2 ? DIV_UART_A : s == 3 ? DIV_UART_B : s == 4 ? DIV_UART_C : DIV_UART_D;
         d = s == 6 ? (idx == 6 ? DIV_SPI_0 : idx == 7 ? DIV_SPI_1 :
            idx == 8 ? DIV_SPI_2 : DIV_SPI_3) : s > 6 ? DIV_I2C : d;
         `CHK({probe.step, probe.iface}, {s, e})
         if (s > 1) `CHK(probe.rate_div, d)
         if (s == 6) `CHK(probe.iter, 2'(idx - 6))
         if (gaps && i > first) `CHK(g >= 12 && g <= 18, 1'b1)
         port0_pin_in = ~(8'h01 << p);
         tick(1);
         `CHK(port0_pin_oe, 8'h01 << p)
         `CHK({port0_pin_out, role_in}, {8'h01 << p, 4'hE})
         port0_pin_in = 8'hFF;
      end
   endtask : run_probes
   task automatic t_normal(input logic [15:0] cal);
      restart(1'b1, 16'h0003);
      header.app_flag1 = APP_FLAG1;
      header.app_flag2 = APP_FLAG2;
      header.calib_flags = {cal, 16'h0000};
      nrst = 1'b1;
      for (n = 0; n < 50 && copy_req !== 1'b1; n++) tick(1);
      tick(3);
      `CHK({normal_mode, dev_mode, calib_ok, copy_req, patch_req, address_zero_remap_field},
         {2'h2, cal == CALIB_PATTERN, 3'h4})
      copy_done = 1'b1;
      tick(2);
      copy_done = 1'b0;
      `CHK({copy_req, patch_req}, 2'h1)
      tick(3);
      `CHK(address_zero_remap_field, 1'b0)
      patch_done = 1'b1;
      for (n = 0; n < 20 && boot_done !== 1'b1; n++) tick(1);
      patch_done = 1'b0;
      `CHK({address_zero_remap_field, boot_done}, 2'h3)
      $display("test normal done");
   endtask : t_normal
   task automatic t_modes;
      restart(1'b0, 16'h0003);
      nrst = 1'b1;
      tick(30);
      `CHK({hdr_req, dev_mode, normal_mode, otp_fault}, 4'h0)
      restart(1'b1, 16'h0003);
      header.app_flag1 = APP_FLAG1;
      nrst = 1'b1;
      tick(10);
      `CHK({otp_fault, periph_enable, dev_mode, normal_mode}, 4'hC)
      restart(1'b1, 16'h0003);
      nrst = 1'b1;
      for (n = 0; n < 20 && periph_init !== 1'b1; n++) tick(1);
      `CHK({periph_init, dev_mode, periph_enable, probe.send}, 4'hE)
      run_probes(0, 16, 1'b1);
      $display("test modes done");
   endtask : t_modes
   task automatic t_download;
      restart(1'b1, 16'h0003);
      ans_step = 4'h3;
      fail_dl = 1'b1;
      nrst = 1'b1;
      run_probes(0, 4, 1'b0);
      for (n = 0; n < 10 && dl_start !== 1'b1; n++) tick(1);
      `CHK(dl_start, 1'b1)
      tick(1);
      ans_step = 4'h7;
      fail_dl = 1'b0;
      run_probes(4, 7, 1'b0);
      for (n = 0; n < 30 && boot_done !== 1'b1; n++) tick(1);
      `CHK(boot_done, 1'b1)
      ans_step = 4'hF;
      restart(1'b1, 16'h0003);
      header.user_spi_en = 1'b1;
      header.user_spi_pins = 12'h977;
      nrst = 1'b1;
      wait_send(n);
      `CHK(probe.step, STEP_USER_SPI)
      tick(1);
      `CHK(port0_pin_oe, 8'h80)
      run_probes(0, 2, 1'b0);
      $display("test download done");
   endtask : t_download
   task automatic print_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      t_normal(CALIB_PATTERN);
      t_normal(16'h5A5A);
      t_modes;
      t_download;
      print_verdict;
   end
   initial begin
      #500000;
      fails++;
      print_verdict;
   end
endmodule : boot_probe_sequencer_tb
bind boot_probe_sequencer boot_probe_sequencer_chk i_boot_probe_sequencer_chk (.*);
